// ===== pkg/sarl_pkg.sv
package sarl_pkg;
  // register map, index on the plain port
  localparam logic [3:0] SARL_CFG_OFS = 4'h0;
  localparam logic [3:0] SARL_STAT_OFS = 4'h1;
  localparam logic [3:0] SARL_IRQ_STAT_OFS = 4'h2;
  localparam logic [3:0] SARL_IRQ_CLR_OFS = 4'h3;
  localparam logic [3:0] SARL_IRQ_EN_OFS = 4'h4;
  // config fields
  localparam int SARL_CFG_LATCH_BIT = 0;
  localparam int SARL_CFG_EN_BIT = 1;
  localparam logic [1:0] SARL_CFG_RST = 2'h0;
  // status fields: watchdog flags low, alert flag above
  localparam int SARL_NFAULT = 4;
  localparam int SARL_STAT_FLAG_BIT = 4;
  localparam logic [3:0] SARL_FLAGS_RST = 4'h0;
  // interrupt events
  localparam int SARL_IRQ_ALERT = 0;
  localparam int SARL_IRQ_DONE = 1;
  localparam int SARL_IRQ_LOST = 2;
  localparam logic [2:0] SARL_IRQ_RST = 3'h0;
  // alert response address, read bit appended
  localparam logic [7:0] SARL_ARA_RD = 8'h19;
  localparam logic [3:0] SARL_BITS_BYTE = 4'h8;
  // responder states
  typedef enum logic [2:0] {
    SARL_IDLE = 3'b000,
    SARL_ADDR = 3'b001,
    SARL_ACK = 3'b010,
    SARL_SEND = 3'b011,
    SARL_RACK = 3'b100
  } sarl_state_t;
endpackage

// ===== core/sarl_alert.sv
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
// Notes on behaviour
// R1: respond only when alert enabled, latch mode
// R2: alert stays latched until status read/response
// R3: reassert alert if fault still present
// R4: alert never halts running conversions
// R5: alert pin only pulls low or releases
// R6: host may broadcast read to 0001100
// R7: pending device answers with own address
// R8: lower address wins bit arbitration
// R9: loser keeps alert low, no acknowledge
// R10: finished response releases alert if fault gone
// R11: alert flag cleared by status read/disable
// R12: watchdog flags zero after reset unless alarm
// R13: no pending interrupt: ignore response address
module sarl_alert (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  input wire logic [3:0] fault_in,
  input wire logic [6:0] own_addr,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output logic alert_o,
  output logic alert_oe_n,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [1:0] cfg_r; // latch mode and alert enable
  logic [3:0] flags_r; // sticky watchdog flags
  logic alert_flag_r; // internal alert flag
  logic alert_latch_r; // latched alert, drives the pin in latch mode
  logic [2:0] irq_stat_r; // sticky events
  logic [2:0] irq_en_r; // event enables
  logic [7:0] rd_data_r; // read data, one cycle after strobe
  logic alert_oe_n_r; // pin enable, low pulls line
  logic alert_o_r; // pin level, held low
  logic sda_o_r; // data pin level, held low
  logic sda_oe_n_r; // data pin enable
  logic irq_r; // interrupt level
  logic scl_q_r; // previous clock sample
  logic sda_q_r; // previous data sample
  sarl_pkg::sarl_state_t state_r;
  logic [3:0] cnt_r; // bit counter
  logic [7:0] sh_r; // received address byte
  logic [7:0] tx_r; // outgoing address byte

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire wr_cfg = wr_stb && (addr == sarl_pkg::SARL_CFG_OFS);
  wire rd_stat = rd_stb && (addr == sarl_pkg::SARL_STAT_OFS);
  wire wr_clr = wr_stb && (addr == sarl_pkg::SARL_IRQ_CLR_OFS);
  wire wr_en = wr_stb && (addr == sarl_pkg::SARL_IRQ_EN_OFS);
  wire latch_mode = cfg_r[sarl_pkg::SARL_CFG_LATCH_BIT];
  wire alert_en = cfg_r[sarl_pkg::SARL_CFG_EN_BIT];
  wire fault_any = |fault_in;
  // an alert the response protocol may serve
  wire pending = alert_latch_r && alert_en && latch_mode;

  // bus conditions, pins taken as synchronous
  wire scl_rise = scl_i && !scl_q_r;
  wire scl_fall = !scl_i && scl_q_r;
  wire bus_start = scl_i && scl_q_r && sda_q_r && !sda_i;
  wire bus_stop = scl_i && scl_q_r && !sda_q_r && sda_i;
  wire byte_end = scl_fall && (cnt_r == sarl_pkg::SARL_BITS_BYTE);
  // released bit read back low: someone lower wins
  wire arb_lost = (state_r == sarl_pkg::SARL_SEND) && scl_rise &&
                  tx_r[7] && !sda_i;
  wire ara_done = (state_r == sarl_pkg::SARL_RACK) && scl_rise;

  // read mux; unmapped and write-only offsets read zero
  wire [7:0] stat_word = {3'h0, alert_flag_r, flags_r};
  wire [7:0] rd_mux =
    (addr == sarl_pkg::SARL_CFG_OFS) ? {6'h00, cfg_r} :
    (addr == sarl_pkg::SARL_STAT_OFS) ? stat_word :
    (addr == sarl_pkg::SARL_IRQ_STAT_OFS) ? {5'h00, irq_stat_r} :
    (addr == sarl_pkg::SARL_IRQ_EN_OFS) ? {5'h00, irq_en_r} : 8'h00;

  // latched alert: a fault with the alert enabled wins over any clear in the same cycle
  // R2: clear only by read or response
  wire latch_clr = rd_stat || ara_done;
  // R3: fault still present sets again
  wire latch_set = fault_any && alert_en;
  wire alert_latch_nxt = latch_set || (alert_latch_r && !latch_clr);
  // R11: flag clears on read or disable
  wire flag_clr = rd_stat || !alert_en;
  wire alert_flag_nxt = latch_set || (alert_flag_r && !flag_clr);
  // R12: flags sticky, clear on status read
  wire [3:0] flags_nxt = fault_in | (rd_stat ? 4'h0 : flags_r);

  // pin drive: latched in latch mode, follows fault otherwise
  // R1: comparator mode never latches
  wire alert_drive = alert_en &&
                     (latch_mode ? alert_latch_r : fault_any);

  // events for the interrupt block
  wire alert_rise = alert_latch_nxt && !alert_latch_r;
  wire [2:0] irq_evt = {arb_lost, ara_done, alert_rise};
  wire [2:0] irq_stat_nxt = irq_evt |
                            (irq_stat_r & ~(wr_clr ? wr_data[2:0] : 3'h0));

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= sarl_pkg::SARL_CFG_RST;
      irq_en_r <= sarl_pkg::SARL_IRQ_RST;
      rd_data_r <= 8'h00;
    end else begin
      if (wr_cfg) begin
        cfg_r <= wr_data[1:0];
      end
      if (wr_en) begin
        irq_en_r <= wr_data[2:0];
      end
      rd_data_r <= rd_stb ? rd_mux : 8'h00;
    end
  end

  // status, alert latch and flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // R12: all flags clear out of reset
      flags_r <= sarl_pkg::SARL_FLAGS_RST;
      alert_flag_r <= 1'b0;
      alert_latch_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      alert_flag_r <= alert_flag_nxt;
      alert_latch_r <= alert_latch_nxt;
    end
  end

  // interrupt block; event wins over a write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= sarl_pkg::SARL_IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |(irq_stat_nxt & irq_en_r);
    end
  end

  // alert pin; purely an output, no path into the conversion sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_oe_n_r <= 1'b1;
      alert_o_r <= 1'b0;
    end else begin
      // R4: pin only, conversions unaffected
      // R5: open drain, level always low
      alert_o_r <= 1'b0;
      // R9: a lost response keeps the latch, so the pin stays low
      alert_oe_n_r <= !alert_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling for edge and condition detect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end

  // alert response engine; normal addressing lives in the main slave
  // data changes on clock fall, is sampled on clock rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sarl_pkg::SARL_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      sda_oe_n_r <= 1'b1;
      sda_o_r <= 1'b0;
    end else if (bus_start || bus_stop) begin
      // any start begins a fresh address, stop releases all
      state_r <= bus_start ? sarl_pkg::SARL_ADDR : sarl_pkg::SARL_IDLE;
      cnt_r <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end else begin
      sda_o_r <= 1'b0;
      unique case (state_r)
        sarl_pkg::SARL_IDLE: begin
          sda_oe_n_r <= 1'b1;
        end
        sarl_pkg::SARL_ADDR: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_i};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_end) begin
            // R6: host reads the response address
            // R13: ignore it with nothing pending
            if ((sh_r == sarl_pkg::SARL_ARA_RD) && pending) begin
              state_r <= sarl_pkg::SARL_ACK;
              sda_oe_n_r <= 1'b0;
            end else begin
              state_r <= sarl_pkg::SARL_IDLE;
            end
          end
        end
        sarl_pkg::SARL_ACK: begin
          // R7: after the ack, send own address
          if (scl_fall) begin
            tx_r <= {own_addr, 1'b0};
            sda_oe_n_r <= own_addr[6];
            cnt_r <= 4'h0;
            state_r <= sarl_pkg::SARL_SEND;
          end
        end
        sarl_pkg::SARL_SEND: begin
          if (arb_lost) begin
            // R8: lost arbitration, back off
            state_r <= sarl_pkg::SARL_IDLE;
            sda_oe_n_r <= 1'b1;
          end else if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_end) begin
            state_r <= sarl_pkg::SARL_RACK;
            sda_oe_n_r <= 1'b1;
          end else if (scl_fall) begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe_n_r <= tx_r[6];
          end
        end
        sarl_pkg::SARL_RACK: begin
          // R10: host ack slot ends the response
          if (scl_rise) begin
            state_r <= sarl_pkg::SARL_IDLE;
          end
        end
        default: begin
          state_r <= sarl_pkg::SARL_IDLE;
          sda_oe_n_r <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign rd_data = rd_data_r;
  assign sda_o = sda_o_r;
  assign sda_oe_n = sda_oe_n_r;
  assign alert_o = alert_o_r;
  assign alert_oe_n = alert_oe_n_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // R1: disabled alert leaves the line
  alert_disabled_a: assert property ( // R1
    @(posedge clk) disable iff (!rst_n)
    !alert_en |=> alert_oe_n)
    else $error("alert driven while disabled");

  // R2: latch holds without read or response
  latch_holds_a: assert property ( // R2
    @(posedge clk) disable iff (!rst_n)
    alert_latch_r && !rd_stat && !ara_done |=> alert_latch_r)
    else $error("alert latch dropped without a clear");

  // R3: fault present beats the clear
  alert_reassert_a: assert property ( // R3
    @(posedge clk) disable iff (!rst_n)
    latch_mode && rd_stat && fault_any && alert_en
    |=> alert_latch_r ##1 !alert_oe_n)
    else $error("alert not reasserted on standing fault");

  // R5: never drives high
  alert_open_drain_a: assert property ( // R5
    @(posedge clk) disable iff (!rst_n)
    !alert_o && !sda_o)
    else $error("open drain pin driven high");

  // R7: ack slot pulls data low
  ara_ack_a: assert property ( // R7
    @(posedge clk) disable iff (!rst_n)
    state_r == sarl_pkg::SARL_ACK |-> !sda_oe_n_r)
    else $error("pending responder failed to acknowledge");

  // R13: no pending, no ack
  ara_ignore_a: assert property ( // R13
    @(posedge clk) disable iff (!rst_n)
    (state_r == sarl_pkg::SARL_ADDR) && byte_end && !pending
    && !bus_start && !bus_stop
    |=> sda_oe_n_r && (state_r == sarl_pkg::SARL_IDLE))
    else $error("answered response address with nothing pending");

  // R8: back off on loss
  arb_backoff_a: assert property ( // R8
    @(posedge clk) disable iff (!rst_n)
    arb_lost && !bus_start && !bus_stop
    |=> sda_oe_n_r && (state_r == sarl_pkg::SARL_IDLE))
    else $error("kept driving after losing arbitration");

  // R9: loser keeps alert asserted
  loser_holds_a: assert property ( // R9
    @(posedge clk) disable iff (!rst_n)
    arb_lost && alert_latch_r && !rd_stat |=> ##1 !alert_oe_n)
    else $error("loser released the alert line");

  // R10: finished response with fault gone releases the pin
  done_release_a: assert property ( // R10
    @(posedge clk) disable iff (!rst_n)
    ara_done && !fault_any && latch_mode |=> !alert_latch_r ##1 alert_oe_n)
    else $error("alert kept after completed response");

  // R11: flag cleared by read or disable
  flag_clear_a: assert property ( // R11
    @(posedge clk) disable iff (!rst_n)
    flag_clr && !latch_set |=> !alert_flag_r)
    else $error("alert flag not cleared");

  // R12: read with no alarm empties flags
  flags_clear_a: assert property ( // R12
    @(posedge clk) disable iff (!rst_n)
    rd_stat && (fault_in == 4'h0) |=> flags_r == 4'h0)
    else $error("watchdog flags stuck after read");

  // R1: comparator mode never acks the response
  cmp_no_ack_a: assert property ( // R1
    @(posedge clk) disable iff (!rst_n)
    (state_r == sarl_pkg::SARL_ADDR) && byte_end && !latch_mode
    && !bus_start && !bus_stop
    |=> sda_oe_n_r)
    else $error("answered response address in comparator mode");

  // R9: an idle engine leaves the data line alone
  idle_release_a: assert property ( // R9
    @(posedge clk) disable iff (!rst_n)
    state_r == sarl_pkg::SARL_IDLE |-> sda_oe_n_r)
    else $error("data line pulled while idle");

endmodule

// ===== test/sarl_host.sv
`timescale 1ns/1ns
// smbus host with one optional rival responder on the same wire
module sarl_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // clk cycles per scl high phase, low phase two more; slow against clk
  localparam int HALF = 8;
  // bus idles high, nothing pulled
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bit slot: data moves only while the clock is low
  task automatic slot(input logic lo, output logic v);
    scl <= 1'b0;
    repeat (2) @(posedge clk);
    sda_low <= lo;
    repeat (HALF) @(posedge clk);
    scl <= 1'b1;
    repeat (HALF) @(posedge clk);
    v = sda;
  endtask
  // alert response read; rival pulls low for its zero bits
  task automatic ara(input logic [6:0] rival, input logic rv_on,
                     output logic ack, output logic [7:0] b);
    logic [7:0] ra;
    logic v;
    ra = {rival, 1'b0};
    // start: data falls while clock high
    sda_low <= 1'b1;
    repeat (HALF) @(posedge clk);
    for (int i = 7; i >= 0; i--) begin
      slot(~sarl_pkg::SARL_ARA_RD[i], v);
    end
    slot(rv_on, v);
    ack = ~v;
    for (int i = 7; i >= 0; i--) begin
      slot(rv_on & ~ra[i], v);
      b[i] = v;
    end
    // host nack, then stop
    slot(1'b0, v);
    scl <= 1'b0;
    repeat (2) @(posedge clk);
    sda_low <= 1'b1;
    repeat (HALF) @(posedge clk);
    scl <= 1'b1;
    repeat (HALF) @(posedge clk);
    sda_low <= 1'b0;
    repeat (HALF) @(posedge clk);
  endtask
endmodule

// ===== test/sarl_alert_tb.sv
`timescale 1ns/1ns
// bench for the alert latch and response engine
module sarl_alert_tb;
  logic clk;
  logic rst_n;
  logic [3:0] addr;
  logic [7:0] wr_data;
  logic wr_stb;
  logic rd_stb;
  logic [7:0] rd_data;
  logic [3:0] fault_in;
  logic [6:0] own_addr;
  logic scl;
  logic host_low; // host or rival pulling
  logic sda_o;
  logic sda_oe_n;
  logic alert_o;
  logic alert_oe_n;
  logic irq;
  wire sda;
  int bad_count;
  int cmp_count;
  int cyc_n;
  logic [7:0] v;
  logic ack;
  // pulled-up wire: low whenever any party enables
  assign sda = ~(host_low | ~sda_oe_n);
  sarl_alert i_sarl_alert (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rd_data(rd_data), .fault_in(fault_in), .own_addr(own_addr),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .alert_o(alert_o), .alert_oe_n(alert_oe_n), .irq(irq));
  sarl_host i_sarl_host (.clk(clk), .sda(sda), .scl(scl),
    .sda_low(host_low));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, well above the run length
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 30000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    @(posedge clk);
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
    @(posedge clk);
  endtask
  // one-cycle fault, then time for latch and pin
  task automatic pulse(input logic [3:0] f);
    fault_in <= f;
    @(posedge clk);
    fault_in <= 4'h0;
    cyc(3);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_latch();
    wr(sarl_pkg::SARL_CFG_OFS, 8'h03);
    pulse(4'h2);
    cyc(10);
    chk(alert_oe_n, 8'h00);
    chk(alert_o, 8'h00);
    rd(sarl_pkg::SARL_STAT_OFS, v);
    chk(v, 8'h12);
    cyc(3);
    chk(alert_oe_n, 8'h01);
  endtask
  task automatic t_reassert();
    fault_in <= 4'h4;
    cyc(4);
    rd(sarl_pkg::SARL_STAT_OFS, v);
    chk(v, 8'h14);
    cyc(3);
    chk(alert_oe_n, 8'h00);
    fault_in <= 4'h0;
    rd(sarl_pkg::SARL_STAT_OFS, v);
    cyc(3);
    chk(alert_oe_n, 8'h01);
  endtask
  // sole responder wins; interrupt raised then cleared
  task automatic t_win();
    wr(sarl_pkg::SARL_IRQ_CLR_OFS, 8'h07);
    wr(sarl_pkg::SARL_IRQ_EN_OFS, 8'h02);
    pulse(4'h1);
    i_sarl_host.ara(7'h00, 1'b0, ack, v);
    chk(ack, 8'h01);
    chk(v, 8'h98);
    chk(alert_oe_n, 8'h01);
    chk(irq, 8'h01);
    rd(sarl_pkg::SARL_IRQ_STAT_OFS, v);
    chk(v, 8'h03);
    wr(sarl_pkg::SARL_IRQ_CLR_OFS, 8'h07);
    cyc(2);
    chk(irq, 8'h00);
    rd(sarl_pkg::SARL_STAT_OFS, v);
    chk(v, 8'h11);
  endtask
  // rival with a lower address; lost event stays masked
  task automatic t_lost();
    pulse(4'h1);
    i_sarl_host.ara(7'h48, 1'b1, ack, v);
    chk(v, 8'h90);
    chk(alert_oe_n, 8'h00);
    chk(irq, 8'h00);
    rd(sarl_pkg::SARL_IRQ_STAT_OFS, v);
    chk(v, 8'h05);
    rd(sarl_pkg::SARL_STAT_OFS, v);
    cyc(3);
    chk(alert_oe_n, 8'h01);
  endtask
  task automatic t_nopend();
    i_sarl_host.ara(7'h00, 1'b0, ack, v);
    chk(ack, 8'h00);
    chk(v, 8'hff);
    wr(sarl_pkg::SARL_CFG_OFS, 8'h02);
    fault_in <= 4'h1;
    cyc(3);
    chk(alert_oe_n, 8'h00);
    i_sarl_host.ara(7'h00, 1'b0, ack, v);
    chk(ack, 8'h00);
    fault_in <= 4'h0;
    cyc(3);
    chk(alert_oe_n, 8'h01);
    rd(sarl_pkg::SARL_STAT_OFS, v);
  endtask
  // turning the alert off drops the flag, keeps the fault bit
  task automatic t_disable();
    wr(sarl_pkg::SARL_CFG_OFS, 8'h03);
    pulse(4'h8);
    wr(sarl_pkg::SARL_CFG_OFS, 8'h01);
    cyc(3);
    chk(alert_oe_n, 8'h01);
    rd(sarl_pkg::SARL_STAT_OFS, v);
    chk(v, 8'h08);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    addr = 4'h0;
    wr_data = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    fault_in = 4'h0;
    own_addr = 7'h4c;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({sda_oe_n, alert_oe_n, irq}, 8'h06);
    rd(sarl_pkg::SARL_STAT_OFS, v);
    chk(v, 8'h00);
    rd(sarl_pkg::SARL_CFG_OFS, v);
    chk(v, 8'h00);
    t_latch();
    t_reassert();
    t_win();
    t_lost();
    t_nopend();
    t_disable();
    tally_and_finish();
  end
endmodule
